// ---- verilog/dll_off_to_on_switch_sequencer.sv ----
// Controller that walks a memory device from DLL-off to DLL-on across a clock change in self refresh.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dll_off_to_on_switch_sequencer (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // AXI4-Lite register port
  input  wire logic [dll_switch_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [dll_switch_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  // Readiness from the memory controller, same clock
  input  wire logic                               bank_idle,
  // Clock generator handshake, acknowledgement arrives from outside
  output logic                                    freq_req,
  input  wire logic                               freq_ack,
  // Memory pins
  output logic                                    cke,
  output logic                                    cs_n,
  output logic                                    ras_n,
  output logic                                    cas_n,
  output logic                                    we_n,
  output logic [dll_switch_pkg::BA_W-1:0]         ba,
  output logic [dll_switch_pkg::ADDR_W-1:0]       addr,
  output logic                                    odt,
  output logic                                    seq_busy
);
  import dll_switch_pkg::*;

  // ------------
  // State
  // ------------
  typedef struct packed {
    state_e                         st;
    logic [TIM_W-1:0]               wait_cnt;
    logic [TIM_W-1:0]               dllk_cnt;
    logic [TIM_W-1:0]               zq_cnt;
    logic                           zq_sent;
    logic                           zq_en;
    logic                           ready;
    logic                           refused;
    logic [ADDR_W-1:0]              mr0;
    logic [ADDR_W-1:0]              mr1;
    logic [ADDR_W-1:0]              mr2;
    logic [TIM_N-1:0][TIM_W-1:0]    tim;
    logic                           cke;
    logic [3:0]                     cmd;
    logic [BA_W-1:0]                ba;
    logic [ADDR_W-1:0]              addr;
    logic                           freq_req;
    logic [2:0]                     ack_sync;
    logic                           ack_lvl;
  } top_s;

  top_s s_r;
  top_s s_nxt;

  reg_bus_if rb ();

  axil_slave u_slave (
    .aclk,
    .aresetn,
    .awaddr,
    .awvalid,
    .awready,
    .wdata,
    .wstrb,
    .wvalid,
    .wready,
    .bresp,
    .bvalid,
    .bready,
    .araddr,
    .arvalid,
    .arready,
    .rdata,
    .rresp,
    .rvalid,
    .rready,
    .rb
  );

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // A wait loaded this way lets the next command reach the pins exactly
  // the programmed number of edges after the previous one.
  function automatic logic [TIM_W-1:0] ld(input logic [TIM_W-1:0] t);
    return (t == '0) ? '0 : t - TIM_W'(1); // RULE12
  endfunction

  function automatic logic tim_hit(input logic [AXI_AW-1:0] a);
    return (a >= OFS_TIM_BASE) && (a < OFS_TIM_BASE + AXI_AW'(4 * TIM_N)) && (a[1:0] == 2'b00);
  endfunction

  function automatic int tim_idx(input logic [AXI_AW-1:0] a);
    return int'((a - OFS_TIM_BASE) >> 2);
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic        wr_map;
  logic        start;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_ZQ_EN] = s_r.zq_en;
    stat_word = '0;
    stat_word[ST_BUSY]     = (s_r.st != S_IDLE);
    stat_word[ST_READY]    = s_r.ready;
    stat_word[ST_REFUSED]  = s_r.refused;
    stat_word[ST_DLLK_RUN] = (s_r.dllk_cnt != '0);
    stat_word[ST_FREQ_REQ] = s_r.freq_req;
    stat_word[ST_ZQ_SENT]  = s_r.zq_sent;
  end

  // ------------
  // Register reads
  // ------------
  always_comb begin
    rb.rd_data = '0;
    rb.rd_ok   = 1'b1;
    if (tim_hit(rb.rd_addr)) begin
      rb.rd_data = 32'(s_r.tim[tim_idx(rb.rd_addr)]);
    end else begin
      case (rb.rd_addr)
        OFS_CTRL: rb.rd_data = ctrl_word;
        OFS_STAT: rb.rd_data = stat_word;
        OFS_MR0:  rb.rd_data = 32'(s_r.mr0);
        OFS_MR1:  rb.rd_data = 32'(s_r.mr1);
        OFS_MR2:  rb.rd_data = 32'(s_r.mr2);
        default:  rb.rd_ok   = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (rb.wr_addr)
      OFS_CTRL, OFS_STAT, OFS_MR0, OFS_MR1, OFS_MR2: wr_map = 1'b1;
      default: wr_map = tim_hit(rb.wr_addr);
    endcase
  end
  assign rb.wr_ok = wr_map;
  assign start    = rb.wr_en && (rb.wr_addr == OFS_CTRL) && rb.wr_strb[0] && rb.wr_data[CTRL_START];

  // ------------
  // Sequencer and register file
  // ------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd = CMD_NOP;
    s_nxt.ack_sync = {s_r.ack_sync[1:0], freq_ack};
    if (s_r.ack_sync[1] == s_r.ack_sync[2]) begin
      s_nxt.ack_lvl = s_r.ack_sync[2];
    end
    if (s_r.wait_cnt != '0) begin
      s_nxt.wait_cnt = s_r.wait_cnt - TIM_W'(1);
    end
    if (s_r.dllk_cnt != '0) begin
      s_nxt.dllk_cnt = s_r.dllk_cnt - TIM_W'(1);
    end
    if (s_r.zq_cnt != '0) begin
      s_nxt.zq_cnt = s_r.zq_cnt - TIM_W'(1);
    end

    // Software writes. Settings changed mid-sequence
    // affect the remaining waits.
    if (rb.wr_en) begin
      if (rb.wr_addr == OFS_CTRL && rb.wr_strb[0]) begin
        s_nxt.zq_en = rb.wr_data[CTRL_ZQ_EN];
        if (rb.wr_data[CTRL_CLR_REF]) begin
          s_nxt.refused = 1'b0;
        end
      end
      if (rb.wr_addr == OFS_MR0) begin
        s_nxt.mr0 = ADDR_W'(merge(32'(s_r.mr0), rb.wr_data, rb.wr_strb));
      end
      if (rb.wr_addr == OFS_MR1) begin
        s_nxt.mr1 = ADDR_W'(merge(32'(s_r.mr1), rb.wr_data, rb.wr_strb));
      end
      if (rb.wr_addr == OFS_MR2) begin
        s_nxt.mr2 = ADDR_W'(merge(32'(s_r.mr2), rb.wr_data, rb.wr_strb));
      end
      for (int i = 0; i < TIM_N; i++) begin
        if (tim_hit(rb.wr_addr) && tim_idx(rb.wr_addr) == i) begin
          s_nxt.tim[i] = TIM_W'(merge(32'(s_r.tim[i]), rb.wr_data, rb.wr_strb)); // RULE15
        end
      end
    end

    case (s_r.st)
      S_IDLE: begin
        if (start) begin
          if (bank_idle) begin // RULE1
            s_nxt.cke      = 1'b0;
            s_nxt.cmd      = CMD_REF;
            s_nxt.ready    = 1'b0;
            s_nxt.zq_sent  = 1'b0;
            s_nxt.wait_cnt = ld(s_r.tim[TI_CKSRE]);
            s_nxt.st       = S_SRE_WAIT;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end
      end
      S_SRE_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          s_nxt.freq_req = 1'b1; // RULE2
          s_nxt.st       = S_FREQ;
        end
      end
      S_FREQ: begin
        if (s_r.ack_lvl) begin
          s_nxt.freq_req = 1'b0;
          s_nxt.wait_cnt = ld(s_r.tim[TI_CKSRX]);
          s_nxt.st       = S_CKSRX_WAIT;
        end
      end
      S_CKSRX_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          s_nxt.cke      = 1'b1; // RULE3
          s_nxt.wait_cnt = ld(s_r.tim[TI_XS]);
          s_nxt.st       = S_XS_WAIT;
        end
      end
      S_XS_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          s_nxt.cmd      = CMD_MRS; // RULE6
          s_nxt.ba       = BA_MR1;
          s_nxt.addr     = s_r.mr1;
          s_nxt.addr[MR1_DLL_OFF] = 1'b0;
          s_nxt.wait_cnt = ld(s_r.tim[TI_MRD]);
          s_nxt.st       = S_MR1_WAIT;
        end
      end
      S_MR1_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          s_nxt.cmd      = CMD_MRS; // RULE7
          s_nxt.ba       = BA_MR0;
          s_nxt.addr     = s_r.mr0;
          s_nxt.addr[MR0_DLL_RST] = 1'b1;
          s_nxt.dllk_cnt = s_r.tim[TI_DLLK];
          s_nxt.wait_cnt = ld(s_r.tim[TI_MRD]);
          s_nxt.st       = S_MR0R_WAIT;
        end
      end
      S_MR0R_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          s_nxt.cmd      = CMD_MRS; // RULE8
          s_nxt.ba       = BA_MR2;
          s_nxt.addr     = s_r.mr2;
          s_nxt.wait_cnt = ld(s_r.tim[TI_MRD]);
          s_nxt.st       = S_MR2_WAIT;
        end
      end
      S_MR2_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          // The final MR0 write carries the new latencies without the reset bit.
          s_nxt.cmd      = CMD_MRS; // RULE8
          s_nxt.ba       = BA_MR0;
          s_nxt.addr     = s_r.mr0;
          s_nxt.addr[MR0_DLL_RST] = 1'b0;
          s_nxt.wait_cnt = ld(s_r.tim[TI_MOD]);
          s_nxt.st       = S_MOD_WAIT;
        end
      end
      S_MOD_WAIT: begin
        if (s_r.wait_cnt == '0) begin
          if (s_r.zq_en) begin
            s_nxt.cmd     = CMD_ZQ; // RULE9
            s_nxt.addr    = '0;
            s_nxt.addr[ZQ_LONG_BIT] = 1'b1;
            s_nxt.zq_cnt  = s_r.tim[TI_ZQOPER];
            s_nxt.zq_sent = 1'b1;
          end
          s_nxt.st = S_FINAL;
        end
      end
      S_FINAL: begin
        if (s_r.dllk_cnt == '0 && s_r.zq_cnt == '0) begin // RULE10 RULE11
          s_nxt.ready = 1'b1;
          s_nxt.st    = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase

    if (!aresetn) begin
      s_nxt       = '0;
      s_nxt.st    = S_IDLE;
      s_nxt.cke   = 1'b1;
      s_nxt.cmd   = CMD_NOP;
      s_nxt.tim   = TIM_RST;
      s_nxt.zq_en = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  // ------------
  // Pins
  // ------------
  // Between exit and the end of the lock window cke is never lowered,
  // since only the idle start path drops it.
  assign cke      = s_r.cke; // RULE4
  assign cs_n     = s_r.cmd[3];
  assign ras_n    = s_r.cmd[2];
  assign cas_n    = s_r.cmd[1];
  assign we_n     = s_r.cmd[0];
  assign ba       = s_r.ba;
  assign addr     = s_r.addr;
  // Termination is held off throughout, which is safe whatever the mode
  // registers held at entry.
  assign odt      = 1'b0; // RULE5
  assign freq_req = s_r.freq_req;
  assign seq_busy = (s_r.st != S_IDLE);

endmodule
`default_nettype wire

// ---- verilog/dll_switch_pkg.sv ----
// Constants, encodings and state type shared by the DLL off-to-on switch sequencer.
// Behaviour
// RULE1: Start only from idle, precharged, termination off.
// RULE2: Wait tCKSRE after self refresh entry.
// RULE3: Stable new clock tCKSRX before exit.
// RULE4: CKE high from exit until tDLLK.
// RULE5: ODT low until tDLLK after reset.
// RULE6: After tXS write MR1 with A0 cleared.
// RULE7: After tMRD write MR0 with A8 set.
// RULE8: After tMRD program new mode registers.
// RULE9: ZQ long calibration only after tMOD.
// RULE10: Wait tMOD; withhold locked-DLL commands until tDLLK.
// RULE11: Also wait tZQoper after ZQ calibration.
// RULE12: Count intervals as real clock edges.
// RULE13: Nanoseconds to cycles, rounded up.
// RULE14: Device DLL off while MR1 A0 is 1.
// RULE15: Each wait held in writable count register.
package dll_switch_pkg;

  // ------------
  // Widths and clock
  // ------------
  localparam int AXI_AW = 8;
  localparam int ADDR_W = 14;
  localparam int BA_W   = 3;
  localparam int TIM_W  = 16;
  localparam int TIM_N  = 7;
  localparam int CLK_PS = 4000;

  // ------------
  // Timing defaults
  // ------------
  localparam int CKSRE_NS   = 10;
  localparam int CKSRX_NS   = 10;
  localparam int XS_NS      = 270;
  localparam int MRD_NCK    = 4;
  localparam int MOD_NCK    = 12;
  localparam int DLLK_NCK   = 512;
  localparam int ZQOPER_NCK = 256;
  localparam int CKSRE_CYC  = (CKSRE_NS * 1000 + CLK_PS - 1) / CLK_PS; // RULE13
  localparam int CKSRX_CYC  = (CKSRX_NS * 1000 + CLK_PS - 1) / CLK_PS; // RULE13
  localparam int XS_CYC     = (XS_NS * 1000 + CLK_PS - 1) / CLK_PS; // RULE13

  localparam int TI_CKSRE  = 0;
  localparam int TI_CKSRX  = 1;
  localparam int TI_XS     = 2;
  localparam int TI_MRD    = 3;
  localparam int TI_MOD    = 4;
  localparam int TI_DLLK   = 5;
  localparam int TI_ZQOPER = 6;
  localparam logic [TIM_N-1:0][TIM_W-1:0] TIM_RST = {
    TIM_W'(ZQOPER_NCK), TIM_W'(DLLK_NCK), TIM_W'(MOD_NCK), TIM_W'(MRD_NCK),
    TIM_W'(XS_CYC), TIM_W'(CKSRX_CYC), TIM_W'(CKSRE_CYC)};

  // ------------
  // Register map
  // ------------
  localparam logic [AXI_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STAT     = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_MR0      = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_MR1      = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_MR2      = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_TIM_BASE = 8'h20;
  localparam int CTRL_START   = 0;
  localparam int CTRL_ZQ_EN   = 1;
  localparam int CTRL_CLR_REF = 2;
  localparam int ST_BUSY      = 0;
  localparam int ST_READY     = 1;
  localparam int ST_REFUSED   = 2;
  localparam int ST_DLLK_RUN  = 3;
  localparam int ST_FREQ_REQ  = 4;
  localparam int ST_ZQ_SENT   = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------
  // Memory commands and mode register fields
  // ------------
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_REF  = 4'h1;
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam logic [3:0] CMD_ZQ   = 4'h6;
  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam int MR1_DLL_OFF = 0;
  localparam int MR0_DLL_RST = 8;
  localparam int ZQ_LONG_BIT = 10;

  typedef enum logic [3:0] {
    S_IDLE, S_SRE_WAIT, S_FREQ, S_CKSRX_WAIT, S_XS_WAIT, S_MR1_WAIT,
    S_MR0R_WAIT, S_MR2_WAIT, S_MOD_WAIT, S_FINAL
  } state_e;

endpackage

// ---- verilog/reg_bus_if.sv ----
// Register access strobes between the bus slave and the sequencer register file.
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
  import dll_switch_pkg::*;
  logic                   wr_en;
  logic [AXI_AW-1:0]      wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic                   wr_ok;
  logic                   rd_en;
  logic [AXI_AW-1:0]      rd_addr;
  logic [31:0]            rd_data;
  logic                   rd_ok;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ---- verilog/axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`default_nettype none
module axil_slave (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [dll_switch_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [dll_switch_pkg::AXI_AW-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [31:0]                         rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  reg_bus_if.bus                              rb
);
  import dll_switch_pkg::*;

  typedef struct packed {
    logic              aw_held;
    logic [AXI_AW-1:0] awaddr;
    logic              w_held;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } slv_s;

  slv_s s_r;
  slv_s s_nxt;

  // Address and data park until both arrive; one write at a time.
  assign awready    = !s_r.aw_held && !s_r.bvalid;
  assign wready     = !s_r.w_held && !s_r.bvalid;
  assign arready    = !s_r.rvalid;
  assign rb.wr_en   = s_r.aw_held && s_r.w_held;
  assign rb.wr_addr = s_r.awaddr;
  assign rb.wr_data = s_r.wdata;
  assign rb.wr_strb = s_r.wstrb;
  assign rb.rd_en   = arvalid && !s_r.rvalid;
  assign rb.rd_addr = araddr;
  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign rvalid     = s_r.rvalid;
  assign rdata      = s_r.rdata;
  assign rresp      = s_r.rresp;

  always_comb begin
    s_nxt = s_r;
    if (awvalid && awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = wdata;
      s_nxt.wstrb  = wstrb;
    end
    if (rb.wr_en) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (rb.rd_en) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rb.rd_data;
      s_nxt.rresp  = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

endmodule
`default_nettype wire

// ---- verif/dll_switch_chk.sv ----
// Pin-timing checker for the DLL off-to-on sequencer.
`timescale 1ns/1ps
`default_nettype none
module dll_switch_chk (
  input wire logic                                aclk,
  input wire logic                                aresetn,
  input wire logic                                cke,
  input wire logic                                cs_n,
  input wire logic                                ras_n,
  input wire logic                                cas_n,
  input wire logic                                we_n,
  input wire logic [dll_switch_pkg::BA_W-1:0]     ba,
  input wire logic [dll_switch_pkg::ADDR_W-1:0]   addr,
  input wire logic                                odt,
  input wire logic                                freq_req,
  input wire logic                                seq_busy
);
  import dll_switch_pkg::*;
  localparam int T_DLLK = 60;
  localparam int T_ZQ   = 30;
  logic [3:0]  cmd;
  logic        rst_c;
  logic        ex_r;
  logic [15:0] mod_r, dll_r, zq_r;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign rst_c = cmd == CMD_MRS && ba == BA_MR0 && addr[MR0_DLL_RST];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Ages saturate, so a long idle gap never wraps into a false short interval.
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (&v) ? v : v + 16'h1;
  endfunction
  always_ff @(posedge aclk) begin
    mod_r <= !aresetn ? 16'hffff : cmd == CMD_MRS ? 16'h1 : inc(mod_r);
    dll_r <= !aresetn ? 16'hffff : rst_c ? 16'h1 : inc(dll_r);
    zq_r  <= !aresetn ? 16'hffff : cmd == CMD_ZQ ? 16'h1 : inc(zq_r);
    ex_r  <= (!aresetn || !seq_busy) ? 1'b0 : cmd == CMD_MRS ? 1'b1 : ex_r;
  end
  sequence s_mr1; cmd == CMD_MRS && ba == BA_MR1; endsequence
  sequence s_rst; rst_c; endsequence
  sequence s_mr2; cmd == CMD_MRS && ba == BA_MR2; endsequence
  property p_sre; $fell(cke) |-> cmd == CMD_REF; endproperty
  property p_freq; freq_req |-> !cke; endproperty
  property p_exit; $rose(cke) |-> cmd == CMD_NOP && !freq_req; endproperty
  property p_cke; ex_r |-> cke; endproperty
  property p_odt; !odt; endproperty
  property p_mr1; s_mr1 |-> !addr[MR1_DLL_OFF]; endproperty
  property p_rst; s_mr1 |-> ##4 s_rst; endproperty
  property p_mode; s_rst |-> ##4 s_mr2 ##4 (cmd == CMD_MRS && ba == BA_MR0 && !addr[MR0_DLL_RST]); endproperty
  property p_mrd; cmd == CMD_MRS |=> (cmd != CMD_MRS) [*3]; endproperty
  property p_zq; cmd == CMD_ZQ |-> mod_r >= MOD_NCK && addr[ZQ_LONG_BIT]; endproperty
  property p_done; $fell(seq_busy) |-> dll_r >= T_DLLK && zq_r >= T_ZQ && cmd == CMD_NOP; endproperty
  a_sre: assert property (p_sre) else $error("entry without refresh");
  a_freq: assert property (p_freq) else $error("clock change outside self refresh");
  a_exit: assert property (p_exit) else $error("bad exit");
  a_cke: assert property (p_cke) else $error("cke dropped");
  a_odt: assert property (p_odt) else $error("odt high");
  a_mr1: assert property (p_mr1) else $error("dll left off");
  a_rst: assert property (p_rst) else $error("dll reset late");
  a_mode: assert property (p_mode) else $error("mode writes out of order");
  a_mrd: assert property (p_mrd) else $error("mode writes too close");
  a_zq: assert property (p_zq) else $error("calibration too early");
  a_done: assert property (p_done) else $error("ready too early");
endmodule
bind dll_off_to_on_switch_sequencer dll_switch_chk i_chk (.aclk, .aresetn, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .ba, .addr, .odt, .freq_req, .seq_busy);
`default_nettype wire

// ---- verif/dram_dev_model.sv ----
// Memory-device model with its mode register 1, DLL state and the clock source.
`timescale 1ns/1ps
`default_nettype none
module dram_dev_model (
  input wire logic                              aclk,
  input wire logic                              aresetn,
  input wire logic                              cke,
  input wire logic                              cs_n,
  input wire logic                              ras_n,
  input wire logic                              cas_n,
  input wire logic                              we_n,
  input wire logic [dll_switch_pkg::BA_W-1:0]   ba,
  input wire logic [dll_switch_pkg::ADDR_W-1:0] addr,
  input wire logic                              freq_req,
  output logic                                  freq_ack,
  output logic                                  dll_on,
  output logic                                  dll_rst,
  output logic [dll_switch_pkg::ADDR_W-1:0]     mr1,
  output int                                    n_mrs,
  output int                                    n_zq
);
  import dll_switch_pkg::*;
  logic [4:0] ack_r = '0;
  logic [3:0] cmd;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // The clock source is slow, and drops its answer only after the request goes.
  assign freq_ack = ack_r[4];
  always_ff @(posedge aclk) begin
    ack_r <= {ack_r[3:0], freq_req & aresetn};
    if (!aresetn) begin
      dll_on <= 1'b0;
      dll_rst <= 1'b0;
      mr1 <= '0;
      n_mrs <= 0;
      n_zq <= 0;
    end else if (cke && cmd == CMD_MRS) begin
      n_mrs <= n_mrs + 1;
      if (ba == BA_MR1) begin
        mr1 <= addr;
        dll_on <= !addr[MR1_DLL_OFF];
      end
      if (ba == BA_MR0 && addr[MR0_DLL_RST]) dll_rst <= 1'b1;
    end else if (cke && cmd == CMD_ZQ) n_zq <= n_zq + 1;
  end
endmodule
`default_nettype wire

// ---- verif/dll_off_to_on_switch_sequencer_bench.sv ----
// Self-checking bench for the DLL off-to-on sequencer.
`timescale 1ns/1ps
`default_nettype none
module dll_off_to_on_switch_sequencer_bench;
  import dll_switch_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bank_idle;
  logic              awready, wready, bvalid, arready, rvalid, freq_req, freq_ack;
  logic              cke, cs_n, ras_n, cas_n, we_n, odt, seq_busy, dll_on, dll_rst;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr, mr1, mrv;
  logic [15:0]       tv [7] = '{16'h3, 16'h3, 16'h14, 16'h4, 16'hc, 16'h3c, 16'h1e};
  logic [34:0]       exp_q[$];
  int                n_errors, tests_run, n_mrs, n_zq, seed;
  dll_off_to_on_switch_sequencer i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .bank_idle, .freq_req, .freq_ack, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt, .seq_busy);
  dram_dev_model i_dev (.aclk, .aresetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .freq_req, .freq_ack,
    .dll_on, .dll_rst, .mr1, .n_mrs, .n_zq);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input logic bad);
    if (bad) begin
      n_errors++;
      results();
    end
  endtask
  // Expected answers wait here for the monitor. bready and rready stay high,
  // so back-to-back calls never lower and raise a strobe in one step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    exp_q.push_back({!w, r, w ? 32'h0 : d});
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, arvalid} <= {w, w, !w};
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (w ? bvalid : rvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end
    tmo(k == 200);
  endtask
  task automatic run_seq(input logic zq);
    int k;
    xfer('1, OFS_CTRL, {30'h0, zq, 1'b1}, RESP_OKAY);
    repeat (2) @(posedge aclk);
    for (k = 0; k < 2000; k++) begin
      @(posedge aclk);
      if (!seq_busy) break;
    end
    tmo(k == 2000);
  endtask
  always @(posedge aclk) begin
    if (bvalid && bready) chk({1'b0, bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) chk({1'b1, rresp, rdata}, exp_q.pop_front());
  end
  initial begin
    seed = 32'h8ce1;
    {aresetn, awvalid, wvalid, arvalid, bank_idle} = '0;
    {awaddr, araddr, wdata} = '0;
    {wstrb, bready, rready} = '1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    xfer('0, OFS_CTRL, 32'h2, RESP_OKAY);
    xfer('0, OFS_STAT, 32'h0, RESP_OKAY);
    for (int i = 0; i < TIM_N; i++) xfer('0, OFS_TIM_BASE + 8'(4 * i), 32'(TIM_RST[i]), RESP_OKAY);
    xfer('0, 8'h1c, 32'h0, RESP_SLVERR);
    xfer('1, 8'h1c, 32'h1, RESP_SLVERR);
    xfer('1, OFS_STAT, 32'h3f, RESP_OKAY);
    for (int i = 0; i < TIM_N; i++) xfer('1, OFS_TIM_BASE + 8'(4 * i), 32'(tv[i]), RESP_OKAY);
    xfer('0, OFS_TIM_BASE + 8'h14, 32'h3c, RESP_OKAY);
    mrv = 14'($random(seed)) | 14'h1;
    xfer('1, OFS_MR1, 32'(mrv), RESP_OKAY);
    xfer('1, OFS_MR0, $random(seed), RESP_OKAY);
    xfer('1, OFS_MR2, $random(seed), RESP_OKAY);
    xfer('0, OFS_MR1, 32'(mrv), RESP_OKAY);
    xfer('1, OFS_CTRL, 32'h3, RESP_OKAY);
    xfer('0, OFS_STAT, 32'h4, RESP_OKAY);
    xfer('1, OFS_CTRL, 32'h6, RESP_OKAY);
    xfer('0, OFS_STAT, 32'h0, RESP_OKAY);
    bank_idle <= 1'b1;
    run_seq(1'b1);
    xfer('0, OFS_STAT, 32'h22, RESP_OKAY);
    chk(35'(dll_on), 35'h1);
    chk(35'(mr1), 35'(mrv & ~14'h1));
    chk(35'(dll_rst), 35'h1);
    chk(35'(n_mrs), 35'h4);
    chk(35'(n_zq), 35'h1);
    run_seq(1'b0);
    xfer('0, OFS_STAT, 32'h2, RESP_OKAY);
    chk(35'(n_zq), 35'h1);
    results();
  end
endmodule
`default_nettype wire
